// File: bench/pfs_host_model.sv
// Host side serial model that frames clocks and issues decoder pulses.
`timescale 1ns/100ps
`default_nettype none
module pfs_host_model (
	input wire logic clk_sys,
	output logic sclk_pin,
	output logic cs_n_pin,
	output logic crc_mismatch,
	output logic valid_cmd,
	output logic secondary_status_register_read
);
	// ============================================================
	// The serial clock rests low outside frames; each level lasts three system clocks
	// so the synchronisers never miss an edge.
	initial {sclk_pin, cs_n_pin, crc_mismatch, valid_cmd, secondary_status_register_read} = 5'h08;
	task automatic step(input logic s);
		sclk_pin <= s;
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic frame(input int n, input logic bad);
		@(posedge clk_sys);
		cs_n_pin <= 1'b0;
		repeat (3) @(posedge clk_sys);
		for (int i = 0; i < n; i++) begin
			step(1'b1);
			step(1'b0);
		end
		crc_mismatch <= bad;
		@(posedge clk_sys);
		crc_mismatch <= 1'b0;
		cs_n_pin <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic pulse_cmd(input logic cmd, input logic rd);
		@(posedge clk_sys);
		valid_cmd <= cmd;
		@(posedge clk_sys);
		valid_cmd <= 1'b0;
		secondary_status_register_read <= rd;
		@(posedge clk_sys);
		secondary_status_register_read <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
endmodule // pfs_host_model
`default_nettype wire

// File: bench/pfs_monitor.sv
// Checker for flag timing, flag clearing and read data of the fault status block.
`timescale 1ns/100ps
`default_nettype none
module pfs_monitor import pfs_pkg::*; (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic primary_overvoltage_det,
	input wire logic drive_in_pos,
	input wire logic drive_in_neg,
	input wire logic regulator_ilimit_det,
	input wire logic rail_fault_det,
	input wire logic crc_mismatch,
	input wire logic secondary_status_register_read,
	input wire logic s_axi_rvalid,
	input wire logic [pfs_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic irq,
	input wire pfs_pkg::pfs_flags_t fault_flags
);
	logic [1:0] up_r;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// ============================================================
	// Flags lag their pins by three edges, so level checks wait that long after reset.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) up_r <= 2'h0;
		else if (up_r != 2'h3) up_r <= up_r + 2'h1;
	end
	AST_OV: assert property (up_r == 2'h3 |-> fault_flags.overvolt ==
		$past(primary_overvoltage_det, 3)) else $error("ov flag wrong");
	AST_SHOOT: assert property (up_r == 2'h3 |-> fault_flags.shoot ==
		($past(drive_in_pos, 3) & $past(drive_in_neg, 3))) else $error("shoot flag wrong");
	AST_ILIM: assert property (up_r == 2'h3 |-> fault_flags.ilimit ==
		$past(regulator_ilimit_det, 3)) else $error("ilimit flag wrong");
	AST_RAIL: assert property (up_r == 2'h3 |-> fault_flags.rail ==
		$past(rail_fault_det, 3)) else $error("rail flag wrong");
	AST_CRC: assert property (crc_mismatch |=> fault_flags.comm)
		else $error("comm not set");
	AST_CLEAR: assert property ($fell(fault_flags.comm) |-> $past(secondary_status_register_read))
		else $error("comm cleared early");
	AST_RESET: assert property (up_r == 2'h0 |-> fault_flags == 5'h00)
		else $error("flags not zero");
	AST_RDATA: assert property (s_axi_rvalid |-> s_axi_rdata[31:13] == 19'h0_0000 &&
		s_axi_rdata[7:0] == 8'h00) else $error("spare read bits set");
	cover property ($fell(fault_flags.comm));
	cover property (fault_flags.shoot);
	cover property ($rose(irq));
endmodule // pfs_monitor
bind pfs_top pfs_monitor i_mon (.clk_sys, .rstn, .primary_overvoltage_det, .drive_in_pos,
	.drive_in_neg, .regulator_ilimit_det, .rail_fault_det, .crc_mismatch, .secondary_status_register_read,
	.s_axi_rvalid, .s_axi_rdata, .irq, .fault_flags);
`default_nettype wire

// File: bench/testbench.sv
// Self-checking testbench of the fault status block over its register bus.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import pfs_pkg::*;
	logic clk_sys, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, rd_v, e;
	logic [3:0] s_axi_wstrb;
	logic [4:0] pin_v;
	logic [1:0] resp;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	wire logic sclk_pin, cs_n_pin, crc_mismatch, valid_cmd, secondary_status_register_read;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire pfs_flags_t fault_flags;
	int bad_count = 0, checks = 0, cyc = 0;
	logic [4:0] pat [7] = '{5'h10, 5'h08, 5'h04, 5'h0c, 5'h02, 5'h01, 5'h00};
	int fn [5] = '{16, 15, 32, 17, 1};
	pfs_top i_dut (.clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .primary_overvoltage_det(pin_v[4]),
		.drive_in_pos(pin_v[3]), .drive_in_neg(pin_v[2]), .regulator_ilimit_det(pin_v[1]),
		.rail_fault_det(pin_v[0]), .sclk_pin, .cs_n_pin, .crc_mismatch, .valid_cmd,
		.secondary_status_register_read, .fault_flags, .irq);
	pfs_host_model i_host (.clk_sys, .sclk_pin, .cs_n_pin, .crc_mismatch, .valid_cmd,
		.secondary_status_register_read);
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// ============================================================
	// Bus tasks sample handshakes at the edge, before the block's own updates land.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		resp = s_axi_bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		rd_v = s_axi_rdata;
		resp = s_axi_rresp;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] x);
		rd(a);
		check(rd_v, x);
	endtask
	function automatic logic [31:0] exp_of(input logic [4:0] v);
		return {19'h0_0000, v[4], v[3] & v[2], v[1], 1'b0, v[0], 8'h00};
	endfunction
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			print_verdict();
		end
	end
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h0_0000;
		s_axi_wdata = 32'h0000_0000;
		pin_v = 5'h00;
		rstn = 1'b0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		rchk(FAULT_OFS, 32'h0000_0000);
		rchk(IRQ_MASK_OFS, 32'h0000_0000);
		$display("test reset done");
		foreach (pat[i]) begin
			@(posedge clk_sys);
			pin_v <= pat[i];
			repeat (4) @(posedge clk_sys);
			rchk(FAULT_OFS, exp_of(pat[i]));
			check(32'(fault_flags), exp_of(pat[i]) >> 8);
		end
		$display("test pins done");
		wr(FAULT_OFS, 32'hffff_ffff, 4'hf);
		check(32'(resp), 32'(RESP_OKAY));
		rchk(FAULT_OFS, 32'h0000_0000);
		wr(8'h0c, 32'hffff_ffff, 4'hf);
		check(32'(resp), 32'(RESP_SLVERR));
		rchk(8'h0c, 32'h0000_0000);
		check(32'(resp), 32'(RESP_SLVERR));
		$display("test access done");
		foreach (fn[i]) begin
			i_host.frame(fn[i], fn[i] == 32);
			e = (fn[i] % FRAME_BITS != 0 || fn[i] == 32) ? 32'h0000_0200 : 32'h0000_0000;
			rchk(FAULT_OFS, e);
			i_host.pulse_cmd(1'b0, 1'b1);
			rchk(FAULT_OFS, e);
			i_host.pulse_cmd(1'b1, 1'b1);
			rchk(FAULT_OFS, 32'h0000_0000);
		end
		$display("test serial done");
		rd(IRQ_STAT_OFS);
		wr(IRQ_MASK_OFS, 32'h0000_1000, 4'hd);
		rchk(IRQ_MASK_OFS, 32'h0000_0000);
		wr(IRQ_MASK_OFS, 32'h0000_1000, 4'h2);
		rchk(IRQ_MASK_OFS, 32'h0000_1000);
		pin_v <= 5'h0c;
		repeat (8) @(posedge clk_sys);
		check(32'(irq), 32'h0000_0000);
		rchk(IRQ_STAT_OFS, 32'h0000_0800);
		pin_v <= 5'h1c;
		repeat (8) @(posedge clk_sys);
		check(32'(irq), 32'h0000_0001);
		rchk(IRQ_STAT_OFS, 32'h0000_1000);
		repeat (2) @(posedge clk_sys);
		check(32'(irq), 32'h0000_0000);
		rchk(IRQ_STAT_OFS, 32'h0000_0000);
		$display("test interrupt done");
		print_verdict();
	end
endmodule // testbench
`default_nettype wire

// File: hw/pfs_pkg.sv
// Package of constants and types for the primary fault status bits block.
package pfs_pkg;

	// ============================================================
	// Register bus layout
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam logic [7:0] FAULT_OFS = 8'h00;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h04;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h08;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ============================================================
	// Flag positions within each status word
	localparam int unsigned FLAG_LSB = 8;
	localparam int unsigned FLAG_MSB = 12;
	localparam int unsigned FLAG_N = 5;
	localparam int unsigned OVERVOLT_BIT = 12;
	localparam int unsigned SHOOT_BIT = 11;
	localparam int unsigned ILIMIT_BIT = 10;
	localparam int unsigned COMM_BIT = 9;
	localparam int unsigned RAIL_BIT = 8;
	localparam int unsigned MASK_LANE = 1;

	// ============================================================
	// Reset values
	localparam logic [4:0] FLAGS_RST = 5'h0;
	localparam logic [4:0] MASK_RST = 5'h0;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	// ============================================================
	// Serial framing
	localparam int unsigned FRAME_BITS = 16;
	localparam int unsigned FRAME_CNT_W = $clog2(FRAME_BITS);

	// ============================================================
	// Synchroniser lanes for pins from outside the clock domain
	localparam int unsigned PIN_N = 7;
	localparam int unsigned PIN_OV = 0;
	localparam int unsigned PIN_INP = 1;
	localparam int unsigned PIN_INN = 2;
	localparam int unsigned PIN_ILIM = 3;
	localparam int unsigned PIN_RAIL = 4;
	localparam int unsigned PIN_SCLK = 5;
	localparam int unsigned PIN_CSN = 6;
	localparam logic [6:0] PIN_RST = 7'h40;

	// Field order matches bits 12 down to 8 of the status word.
	typedef struct packed {
		logic overvolt;
		logic shoot;
		logic ilimit;
		logic comm;
		logic rail;
	} pfs_flags_t;

	typedef enum logic [0:0] {
		CLR_IDLE = 1'b0,
		CLR_ARMED = 1'b1
	} pfs_clr_st_t;

endpackage

// File: hw/pfs_top.sv
// Primary fault status bits with AXI4-Lite access and a maskable interrupt.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Bit 12 reads 1 while the primary supply is above its overvoltage threshold, else 0.
// - Bit 11 is set while both drive inputs are high at the same time.
// - Bit 10 is set while the primary internal regulator is in current limit.
// - Bit 9 is set when a chip-select frame ends after a clock count not a multiple of 16.
// - Bit 9 is also set when a frame's check value does not match the device's own.
// - Bit 9 clears only after a valid command followed by a read of the secondary status register.
// - Bit 8 is set when any primary internal rail, the regulator included, is over or under voltage.
module pfs_top (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [pfs_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [pfs_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [pfs_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [pfs_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic primary_overvoltage_det,
	input wire logic drive_in_pos,
	input wire logic drive_in_neg,
	input wire logic regulator_ilimit_det,
	input wire logic rail_fault_det,
	input wire logic sclk_pin,
	input wire logic cs_n_pin,
	input wire logic crc_mismatch,
	input wire logic valid_cmd,
	input wire logic secondary_status_register_read,
	output pfs_pkg::pfs_flags_t fault_flags,
	output logic irq
);
	import pfs_pkg::*;

	// ============================================================
	// Pin synchronisers
	logic [PIN_N-1:0] pin_raw;
	logic [PIN_N-1:0] meta_r;
	logic [PIN_N-1:0] sync_r;
	logic [PIN_N-1:0] meta_nxt;
	logic [PIN_N-1:0] sync_nxt;

	assign pin_raw = {cs_n_pin, sclk_pin, rail_fault_det, regulator_ilimit_det,
		drive_in_neg, drive_in_pos, primary_overvoltage_det};

	// The first stage feeds only the second stage, never any logic.
	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++) begin : g_sync
			always_comb begin
				meta_nxt[gi] = pin_raw[gi];
				sync_nxt[gi] = meta_r[gi];
			end
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					meta_r[gi] <= PIN_RST[gi];
					sync_r[gi] <= PIN_RST[gi];
				end else begin
					meta_r[gi] <= meta_nxt[gi];
					sync_r[gi] <= sync_nxt[gi];
				end
			end
		end
	endgenerate

	// ============================================================
	// Serial frame length check
	logic sclk_d_r;
	logic csn_d_r;
	logic [FRAME_CNT_W-1:0] edge_cnt_r;
	logic sclk_d_nxt;
	logic csn_d_nxt;
	logic [FRAME_CNT_W-1:0] edge_cnt_nxt;
	logic frame_end;
	logic frame_bad;

	// Counting modulo 16 is enough: only the remainder decides the fault.
	assign frame_end = sync_r[PIN_CSN] & ~csn_d_r;
	assign frame_bad = frame_end && (edge_cnt_r != '0);

	always_comb begin
		sclk_d_nxt = sync_r[PIN_SCLK];
		csn_d_nxt = sync_r[PIN_CSN];
		edge_cnt_nxt = edge_cnt_r;
		if (!sync_r[PIN_CSN] && csn_d_r) begin
			edge_cnt_nxt = '0;
		end else if (!sync_r[PIN_CSN] && sync_r[PIN_SCLK] && !sclk_d_r) begin
			edge_cnt_nxt = edge_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sclk_d_r <= 1'b0;
			csn_d_r <= 1'b1;
			edge_cnt_r <= '0;
		end else begin
			sclk_d_r <= sclk_d_nxt;
			csn_d_r <= csn_d_nxt;
			edge_cnt_r <= edge_cnt_nxt;
		end
	end

	// ============================================================
	// Fault flags
	pfs_flags_t flags_r;
	pfs_flags_t flags_nxt;
	pfs_clr_st_t clr_st_r;
	pfs_clr_st_t clr_st_nxt;
	logic comm_err;

	assign comm_err = frame_bad | crc_mismatch;

	always_comb begin
		clr_st_nxt = clr_st_r;
		flags_nxt.overvolt = sync_r[PIN_OV];
		flags_nxt.shoot = sync_r[PIN_INP] & sync_r[PIN_INN];
		flags_nxt.ilimit = sync_r[PIN_ILIM];
		flags_nxt.rail = sync_r[PIN_RAIL];
		flags_nxt.comm = flags_r.comm;
		// A fresh error wins over the clear and demands a new valid command.
		case (clr_st_r)
			CLR_IDLE: begin
				if (valid_cmd && !comm_err) begin
					clr_st_nxt = CLR_ARMED;
				end
			end
			CLR_ARMED: begin
				if (comm_err) begin
					clr_st_nxt = CLR_IDLE;
				end else if (secondary_status_register_read) begin
					flags_nxt.comm = 1'b0;
					clr_st_nxt = CLR_IDLE;
				end
			end
			default: begin
				clr_st_nxt = CLR_IDLE;
			end
		endcase
		if (comm_err) begin
			flags_nxt.comm = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			flags_r <= FLAGS_RST;
			clr_st_r <= CLR_IDLE;
		end else begin
			flags_r <= flags_nxt;
			clr_st_r <= clr_st_nxt;
		end
	end

	// ============================================================
	// Interrupt status, mask and output
	logic [FLAG_N-1:0] irq_stat_r;
	logic [FLAG_N-1:0] irq_stat_nxt;
	logic [FLAG_N-1:0] irq_mask_r;
	logic [FLAG_N-1:0] irq_mask_nxt;
	logic [FLAG_N-1:0] irq_clr;
	logic [FLAG_N-1:0] flag_rise;
	logic irq_r;
	logic irq_nxt;
	logic mask_we;

	assign flag_rise = flags_nxt & ~flags_r;

	always_comb begin
		// Set wins: an event in the clearing read's cycle stays pending.
		irq_stat_nxt = (irq_stat_r & ~irq_clr) | flag_rise;
		irq_mask_nxt = irq_mask_r;
		// The captured beat is used: the master may already have moved its data on.
		if (mask_we) begin
			irq_mask_nxt = wdata_r[FLAG_MSB:FLAG_LSB];
		end
		irq_nxt = |(irq_stat_r & irq_mask_r);
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			irq_stat_r <= FLAGS_RST;
			irq_mask_r <= MASK_RST;
			irq_r <= 1'b0;
		end else begin
			irq_stat_r <= irq_stat_nxt;
			irq_mask_r <= irq_mask_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ============================================================
	// AXI4-Lite write channel
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic aw_got_r;
	logic w_got_r;
	logic [ADDR_W-1:0] waddr_r;
	logic awready_nxt;
	logic wready_nxt;
	logic bvalid_nxt;
	logic [1:0] bresp_nxt;
	logic aw_got_nxt;
	logic w_got_nxt;
	logic [ADDR_W-1:0] waddr_nxt;
	logic [ADDR_W-1:0] wword;
	logic do_write;

	// Write data is captured at its handshake, and wready stays low once
	// the beat is taken until the response is accepted.
	logic [DATA_W-1:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [DATA_W-1:0] wdata_nxt;
	logic [3:0] wstrb_nxt;

	assign wword = {waddr_r[ADDR_W-1:2], 2'b00};
	assign do_write = aw_got_r && w_got_r && !bvalid_r;

	always_comb begin
		awready_nxt = awready_r;
		wready_nxt = wready_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		aw_got_nxt = aw_got_r;
		w_got_nxt = w_got_r;
		waddr_nxt = waddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		mask_we = 1'b0;
		if (s_axi_awvalid && awready_r) begin
			aw_got_nxt = 1'b1;
			awready_nxt = 1'b0;
			waddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_r) begin
			w_got_nxt = 1'b1;
			wready_nxt = 1'b0;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		if (do_write) begin
			aw_got_nxt = 1'b0;
			w_got_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			case (wword)
				IRQ_MASK_OFS: begin
					mask_we = wstrb_r[MASK_LANE];
					bresp_nxt = RESP_OKAY;
				end
				FAULT_OFS, IRQ_STAT_OFS: begin
					bresp_nxt = RESP_OKAY;
				end
				default: begin
					bresp_nxt = RESP_SLVERR;
				end
			endcase
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
			awready_nxt = 1'b1;
			wready_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			waddr_r <= '0;
			wdata_r <= RDATA_RST;
			wstrb_r <= '0;
		end else begin
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			waddr_r <= waddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
		end
	end

	// ============================================================
	// AXI4-Lite read channel
	logic arready_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [DATA_W-1:0] rdata_r;
	logic arready_nxt;
	logic rvalid_nxt;
	logic [1:0] rresp_nxt;
	logic [DATA_W-1:0] rdata_nxt;
	logic [ADDR_W-1:0] rword;

	assign rword = {s_axi_araddr[ADDR_W-1:2], 2'b00};

	always_comb begin
		arready_nxt = arready_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		irq_clr = '0;
		if (s_axi_arvalid && arready_r) begin
			arready_nxt = 1'b0;
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			rdata_nxt = RDATA_RST;
			case (rword)
				FAULT_OFS: begin
					rdata_nxt[FLAG_MSB:FLAG_LSB] = flags_r;
				end
				IRQ_STAT_OFS: begin
					rdata_nxt[FLAG_MSB:FLAG_LSB] = irq_stat_r;
					irq_clr = irq_stat_r;
				end
				IRQ_MASK_OFS: begin
					rdata_nxt[FLAG_MSB:FLAG_LSB] = irq_mask_r;
				end
				default: begin
					rresp_nxt = RESP_SLVERR;
				end
			endcase
		end
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
			arready_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= RDATA_RST;
		end else begin
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ============================================================
	// Outputs
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	assign fault_flags = flags_r;
	assign irq = irq_r;

endmodule // pfs_top
`default_nettype wire
